// ### rtl/hdpc_regs.sv
// Packet and pixel configuration register bank with AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
module hdpc_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic dpi_hsync,
    input wire logic dpi_vsync,
    input wire logic dpi_de,
    input wire logic dpi_shutd,
    input wire logic dpi_colorm,
    input wire logic [23:0] dpi_pixel,
    input wire logic dpi_pixel_valid,
    output logic hsync_act,
    output logic vsync_act,
    output logic de_act,
    output logic shutd_act,
    output logic colorm_act,
    output logic [2:0] pixel_class,
    output logic [1:0] pixel_config,
    output logic loose_pack_enable,
    output logic [23:0] video_pixel,
    output logic video_pixel_valid,
    input wire logic vact_region,
    output logic [7:0] lp_budget_outside,
    output logic [7:0] lp_budget_inside,
    output logic [7:0] lp_budget_now,
    input wire logic bta_want,
    output logic bta_request,
    input wire logic tx_end,
    output logic tx_eotp_send,
    input wire logic rx_eotp_seen,
    output logic rx_eotp_accept,
    input wire logic rx_crc_bad,
    output logic crc_error,
    input wire logic rx_ecc_bad,
    input wire logic rx_ecc_fixable,
    output logic ecc_error,
    output logic ecc_correct,
    output logic rx_end_packet_enable,
    output logic tx_end_packet_enable,
    output logic turnaround_request_enable,
    output logic [1:0] readback_vc,
    output logic video_enable
);

    typedef struct packed {
        logic dphase;
        logic dwrite;
        logic [11:0] daddr;
        logic [31:0] rdata;
        logic loose;
        logic [3:0] code;
        logic [4:0] pol;
        logic [7:0] bud_out;
        logic [7:0] bud_in;
        logic [4:0] pkt;
        logic [1:0] vc;
        logic vid_en;
        logic [23:0] pix;
        logic pix_vld;
        logic bta;
        logic eotp_tx;
        logic eotp_rx;
        logic crc_err;
        logic ecc_err;
        logic ecc_fix;
        logic [7:0] bud_now;
    } hdpc_regs_s;

    hdpc_regs_s q;
    hdpc_regs_s d;

    logic [4:0] pins_act;
    logic [2:0] front_class;
    logic [1:0] front_cfg;
    logic front_loose;
    logic [31:0] status_word;
    logic take;

    // Pin polarity and format decoding
    hdpc_dpi_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .pol(q.pol),
        .code(q.code),
        .loose(q.loose),
        .hsync_pin(dpi_hsync),
        .vsync_pin(dpi_vsync),
        .de_pin(dpi_de),
        .shutd_pin(dpi_shutd),
        .colorm_pin(dpi_colorm),
        .pins_act(pins_act),
        .pix_class(front_class),
        .pix_cfg(front_cfg),
        .loose_act(front_loose)
    );

    // Read image of one register word
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input hdpc_regs_s s,
                                              input logic [31:0] st);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            hdpc_pkg::OFS_PIXFMT: begin
                w[hdpc_pkg::LOOSE_BIT] = s.loose;
                w[hdpc_pkg::CODE_LSB +: 4] = s.code;
            end
            hdpc_pkg::OFS_POL: w[4:0] = s.pol;
            hdpc_pkg::OFS_BUDGET: begin
                w[hdpc_pkg::BUD_OUT_LSB +: 8] = s.bud_out;
                w[hdpc_pkg::BUD_IN_LSB +: 8] = s.bud_in;
            end
            hdpc_pkg::OFS_PKTHDL: w[4:0] = s.pkt;
            hdpc_pkg::OFS_RDVC: w[1:0] = s.vc;
            hdpc_pkg::OFS_MODE: w[hdpc_pkg::MODE_VIDEO_BIT] = s.vid_en;
            hdpc_pkg::OFS_STATUS: w = st;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Status word built from live block state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[hdpc_pkg::ST_PINS_LSB +: 5] = pins_act;
        status_word[hdpc_pkg::ST_SHORT_BIT] =
            q.bud_out < hdpc_pkg::MIN_OUT_BUDGET;
        status_word[hdpc_pkg::ST_CLASS_LSB +: 3] = front_class;
        status_word[hdpc_pkg::ST_CFG_LSB +: 2] = front_cfg;
        status_word[hdpc_pkg::ST_LOOSE_BIT] = front_loose;
    end

    assign take = hsel && htrans[1] && hready;

    // Bus slave, register writes and gated datapath
    always_comb begin
        d = q;
        // Data phase of a write updates the addressed word
        if (q.dphase && q.dwrite) begin
            case (q.daddr)
                hdpc_pkg::OFS_PIXFMT: begin
                    d.loose = hwdata[hdpc_pkg::LOOSE_BIT];
                    d.code = hwdata[hdpc_pkg::CODE_LSB +: 4];
                end
                hdpc_pkg::OFS_POL: d.pol = hwdata[4:0];
                hdpc_pkg::OFS_BUDGET: begin
                    d.bud_out = hwdata[hdpc_pkg::BUD_OUT_LSB +: 8];
                    d.bud_in = hwdata[hdpc_pkg::BUD_IN_LSB +: 8];
                end
                hdpc_pkg::OFS_PKTHDL: d.pkt = hwdata[4:0];
                hdpc_pkg::OFS_RDVC: d.vc = hwdata[1:0];
                hdpc_pkg::OFS_MODE: d.vid_en =
                    hwdata[hdpc_pkg::MODE_VIDEO_BIT];
                default: d.vid_en = q.vid_en;
            endcase
        end
        // Address phase; a read of a config word sees any write finishing this cycle, the status word does not
        d.dphase = take;
        d.dwrite = take && hwrite;
        d.daddr = take ? haddr[11:0] : q.daddr;
        if (take && !hwrite) begin
            d.rdata = read_word(haddr[11:0], d, status_word);
        end
        // Video passes only in video mode
        d.pix_vld = q.vid_en && dpi_pixel_valid;
        d.pix = (q.vid_en && dpi_pixel_valid) ? dpi_pixel : q.pix;
        // Budget for the current vertical region
        d.bud_now = vact_region ? q.bud_in : q.bud_out;
        d.bta = bta_want && q.pkt[hdpc_pkg::PKT_BTA_BIT];
        d.eotp_tx = tx_end && q.pkt[hdpc_pkg::PKT_EOT_TX_BIT];
        d.eotp_rx = rx_eotp_seen && q.pkt[hdpc_pkg::PKT_EOT_RX_BIT];
        d.crc_err = rx_crc_bad && q.pkt[hdpc_pkg::PKT_CRC_BIT];
        d.ecc_err = rx_ecc_bad && q.pkt[hdpc_pkg::PKT_ECC_BIT];
        d.ecc_fix = rx_ecc_bad && rx_ecc_fixable
            && q.pkt[hdpc_pkg::PKT_ECC_BIT];
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{dphase: 1'h0, dwrite: 1'h0, daddr: 12'h000,
                   rdata: 32'h0000_0000, loose: hdpc_pkg::RST_LOOSE,
                   code: hdpc_pkg::RST_CODE, pol: hdpc_pkg::RST_POL,
                   bud_out: hdpc_pkg::RST_BUDGET,
                   bud_in: hdpc_pkg::RST_BUDGET,
                   pkt: hdpc_pkg::RST_PKTHDL, vc: hdpc_pkg::RST_RDVC,
                   vid_en: hdpc_pkg::RST_VIDEO, pix: 24'h00_0000,
                   pix_vld: 1'h0, bta: 1'h0, eotp_tx: 1'h0,
                   eotp_rx: 1'h0, crc_err: 1'h0, ecc_err: 1'h0,
                   ecc_fix: 1'h0, bud_now: 8'h00};
        end else begin
            q <= d;
        end
    end

    // Bus answers: zero wait states, always OKAY
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Normalised pins and decoded format
    assign de_act = pins_act[hdpc_pkg::POL_DE_BIT];
    assign vsync_act = pins_act[hdpc_pkg::POL_VS_BIT];
    assign hsync_act = pins_act[hdpc_pkg::POL_HS_BIT];
    assign shutd_act = pins_act[hdpc_pkg::POL_SHUTD_BIT];
    assign colorm_act = pins_act[hdpc_pkg::POL_COLORM_BIT];
    assign pixel_class = front_class;
    assign pixel_config = front_cfg;
    assign loose_pack_enable = front_loose;

    // Configuration and gated link controls
    assign video_pixel = q.pix;
    assign video_pixel_valid = q.pix_vld;
    assign lp_budget_outside = q.bud_out;
    assign lp_budget_inside = q.bud_in;
    assign lp_budget_now = q.bud_now;
    assign bta_request = q.bta;
    assign tx_eotp_send = q.eotp_tx;
    assign rx_eotp_accept = q.eotp_rx;
    assign crc_error = q.crc_err;
    assign ecc_error = q.ecc_err;
    assign ecc_correct = q.ecc_fix;
    assign rx_end_packet_enable = q.pkt[hdpc_pkg::PKT_EOT_RX_BIT];
    assign tx_end_packet_enable = q.pkt[hdpc_pkg::PKT_EOT_TX_BIT];
    assign turnaround_request_enable = q.pkt[hdpc_pkg::PKT_BTA_BIT];
    assign readback_vc = q.vc;
    assign video_enable = q.vid_en;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_VIDEO_GATED: assert property (
        video_pixel_valid |-> $past(video_enable) && $past(dpi_pixel_valid))
        else $error("Pixel passed while video mode off");

    AST_VIDEO_PASS: assert property (
        video_enable && dpi_pixel_valid
        |=> video_pixel_valid && video_pixel == $past(dpi_pixel))
        else $error("Pixel lost in video mode");

    AST_BTA_GATED: assert property (
        bta_request |-> $past(turnaround_request_enable) && $past(bta_want))
        else $error("Turn-around requested while disabled");

    AST_CRC_GATE: assert property (
        rx_crc_bad |=> crc_error == $past(q.pkt[hdpc_pkg::PKT_CRC_BIT]))
        else $error("Checksum report does not follow enable");

    AST_ECC_GATE: assert property (
        ecc_correct |-> ecc_error && $past(q.pkt[hdpc_pkg::PKT_ECC_BIT]))
        else $error("Header correction without check enabled");

    AST_EOTP: assert property (
        tx_eotp_send |-> $past(tx_end_packet_enable) && $past(tx_end))
        else $error("End packet sent while disabled");

    AST_EOTP_RX: assert property (
        rx_eotp_accept |-> $past(rx_end_packet_enable))
        else $error("End packet accepted while disabled");

    AST_BUDGET: assert property (
        ##1 lp_budget_now == ($past(vact_region) ? $past(lp_budget_inside)
                                                 : $past(lp_budget_outside)))
        else $error("Wrong region budget selected");

    // Pin views hold their reset value for one edge after release
    AST_POL_HS: assert property (
        hresetn |=> hsync_act == ($past(dpi_hsync) ^ $past(q.pol[2])))
        else $error("Hsync polarity not applied");

    AST_POL_SD: assert property (
        hresetn |=> shutd_act == ($past(dpi_shutd) ^ $past(q.pol[3])))
        else $error("Shutdown polarity not applied");

    AST_CLASS24: assert property (
        q.code[2:0] >= 3'h5 |=> pixel_class == 3'b100)
        else $error("24-bit code not decoded");

    AST_LOOSE: assert property (
        ##1 loose_pack_enable == ($past(q.loose)
            && $past(q.code[2:0]) inside {3'h3, 3'h4}))
        else $error("Loose packing not tied to 18-bit");

    AST_VC_WRITE: assert property (
        take && hwrite && haddr[11:0] == hdpc_pkg::OFS_RDVC
        ##1 1'b1 |=> readback_vc == $past(hwdata[1:0]))
        else $error("Read-back channel write lost");

    AST_POL_VS: assert property (
        hresetn |=> vsync_act == ($past(dpi_vsync) ^ $past(q.pol[1])))
        else $error("Vsync polarity not applied");

    AST_POL_DE: assert property (
        hresetn |=> de_act == ($past(dpi_de) ^ $past(q.pol[0])))
        else $error("Data enable polarity not applied");

    AST_POL_CM: assert property (
        hresetn |=> colorm_act == ($past(dpi_colorm) ^ $past(q.pol[4])))
        else $error("Colour mode polarity not applied");

    AST_CLASS16: assert property (
        q.code[2:0] < 3'h3 |=> pixel_class == 3'b001)
        else $error("16-bit code not decoded");

    AST_CLASS18: assert property (
        q.code[2:0] inside {3'h3, 3'h4} |=> pixel_class == 3'b010)
        else $error("18-bit code not decoded");

    AST_CFG24: assert property (
        q.code[2:0] >= 3'h5 |=> pixel_config == 2'h0)
        else $error("24-bit code given a configuration");

    AST_ECC_ERR: assert property (
        rx_ecc_bad |=> ecc_error == $past(q.pkt[hdpc_pkg::PKT_ECC_BIT]))
        else $error("Header error report does not follow enable");

    AST_BTA_PASS: assert property (
        bta_want && turnaround_request_enable |=> bta_request)
        else $error("Turn-around request lost while enabled");

    AST_EOTP_TX_PASS: assert property (
        tx_end && tx_end_packet_enable |=> tx_eotp_send)
        else $error("End packet not sent while enabled");

    AST_EOTP_RX_PASS: assert property (
        rx_eotp_seen && rx_end_packet_enable |=> rx_eotp_accept)
        else $error("End packet refused while enabled");

    COV_WRITE_READ: cover property (
        take && hwrite ##1 take && !hwrite);
    COV_VIDEO_ON: cover property (video_pixel_valid);
    COV_BTA: cover property (bta_request);
    COV_ECC_FIX: cover property (ecc_correct);

endmodule

// ### rtl/hdpc_pkg.sv
// Package: register map, field layout and pixel format decoding
package hdpc_pkg;

    // Register byte offsets on the 12-bit decoded window
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_PIXFMT = 12'h010;
    localparam logic [11:0] OFS_POL = 12'h014;
    localparam logic [11:0] OFS_BUDGET = 12'h018;
    localparam logic [11:0] OFS_PKTHDL = 12'h02c;
    localparam logic [11:0] OFS_RDVC = 12'h030;
    localparam logic [11:0] OFS_MODE = 12'h034;
    localparam logic [11:0] OFS_STATUS = 12'h0f0;

    // Field positions
    localparam int unsigned LOOSE_BIT = 8;
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned POL_DE_BIT = 0;
    localparam int unsigned POL_VS_BIT = 1;
    localparam int unsigned POL_HS_BIT = 2;
    localparam int unsigned POL_SHUTD_BIT = 3;
    localparam int unsigned POL_COLORM_BIT = 4;
    localparam int unsigned BUD_OUT_LSB = 16;
    localparam int unsigned BUD_IN_LSB = 0;
    localparam int unsigned PKT_EOT_TX_BIT = 0;
    localparam int unsigned PKT_EOT_RX_BIT = 1;
    localparam int unsigned PKT_BTA_BIT = 2;
    localparam int unsigned PKT_ECC_BIT = 3;
    localparam int unsigned PKT_CRC_BIT = 4;
    localparam int unsigned MODE_VIDEO_BIT = 0;
    localparam int unsigned ST_PINS_LSB = 0;
    localparam int unsigned ST_SHORT_BIT = 5;
    localparam int unsigned ST_CLASS_LSB = 8;
    localparam int unsigned ST_CFG_LSB = 12;
    localparam int unsigned ST_LOOSE_BIT = 16;

    // Reset values
    localparam logic RST_LOOSE = 1'h0;
    localparam logic [3:0] RST_CODE = 4'h0;
    localparam logic [4:0] RST_POL = 5'h00;
    localparam logic [7:0] RST_BUDGET = 8'h00;
    localparam logic [4:0] RST_PKTHDL = 5'h00;
    localparam logic [1:0] RST_RDVC = 2'h0;
    localparam logic RST_VIDEO = 1'h0;

    // Least outside-region budget that fits the display control commands
    localparam logic [7:0] MIN_OUT_BUDGET = 8'h04;

    // Format codes
    localparam logic [2:0] CODE_18_CFG1 = 3'h3;
    localparam logic [2:0] CODE_18_CFG2 = 3'h4;
    localparam logic [2:0] CODE_24_MIN = 3'h5;

    typedef enum logic [2:0] {
        CLS_16 = 3'b001,
        CLS_18 = 3'b010,
        CLS_24 = 3'b100
    } hdpc_class_e;

    // Colour class from the low three bits of the format code
    function automatic hdpc_class_e code_class(input logic [3:0] code);
        if (code[2:0] >= CODE_24_MIN) begin
            return CLS_24;
        end else if (code[2:0] >= CODE_18_CFG1) begin
            return CLS_18;
        end
        return CLS_16;
    endfunction

    // Configuration number (1..3) within the class, zero for 24-bit
    function automatic logic [1:0] code_config(input logic [3:0] code);
        logic [1:0] cfg;
        cfg = 2'h0;
        case (code[2:0])
            3'h0: cfg = 2'h1;
            3'h1: cfg = 2'h2;
            3'h2: cfg = 2'h3;
            CODE_18_CFG1: cfg = 2'h1;
            CODE_18_CFG2: cfg = 2'h2;
            default: cfg = 2'h0;
        endcase
        return cfg;
    endfunction

endpackage

// ### rtl/hdpc_dpi_front.sv
// DPI pin polarity normaliser and pixel format decoder
module hdpc_dpi_front (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [4:0] pol,
    input wire logic [3:0] code,
    input wire logic loose,
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic de_pin,
    input wire logic shutd_pin,
    input wire logic colorm_pin,
    output logic [4:0] pins_act,
    output logic [2:0] pix_class,
    output logic [1:0] pix_cfg,
    output logic loose_act
);

    typedef struct packed {
        logic [4:0] pins;
        logic [2:0] cls;
        logic [1:0] cfg;
        logic loose;
    } hdpc_front_s;

    hdpc_front_s q;
    hdpc_front_s d;

    // Active-high view of each pin, format class decode
    always_comb begin
        d = q;
        d.pins[hdpc_pkg::POL_DE_BIT] = de_pin
            ^ pol[hdpc_pkg::POL_DE_BIT];
        d.pins[hdpc_pkg::POL_VS_BIT] = vsync_pin
            ^ pol[hdpc_pkg::POL_VS_BIT];
        d.pins[hdpc_pkg::POL_HS_BIT] = hsync_pin
            ^ pol[hdpc_pkg::POL_HS_BIT];
        d.pins[hdpc_pkg::POL_SHUTD_BIT] = shutd_pin
            ^ pol[hdpc_pkg::POL_SHUTD_BIT];
        d.pins[hdpc_pkg::POL_COLORM_BIT] = colorm_pin
            ^ pol[hdpc_pkg::POL_COLORM_BIT];
        d.cls = hdpc_pkg::code_class(code);
        d.cfg = hdpc_pkg::code_config(code);
        d.loose = loose
            && (hdpc_pkg::code_class(code) == hdpc_pkg::CLS_18);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{pins: 5'h00, cls: 3'h1, cfg: 2'h1, loose: 1'h0};
        end else begin
            q <= d;
        end
    end

    assign pins_act = q.pins;
    assign pix_class = q.cls;
    assign pix_cfg = q.cfg;
    assign loose_act = q.loose;

endmodule

// ### testbench/hdpc_panel_model.sv
// Display panel side model: link events seen by the packet handler
module hdpc_panel_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [5:0] ev_cmd,
    input wire logic vact_cmd,
    output logic bta_want,
    output logic tx_end,
    output logic rx_eotp_seen,
    output logic rx_crc_bad,
    output logic rx_ecc_bad,
    output logic rx_ecc_fixable,
    output logic vact_region
);
    timeunit 1ns;
    timeprecision 100ps;

    // Events show one cycle after the bench asks; reset clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bta_want <= 1'b0;
            tx_end <= 1'b0;
            rx_eotp_seen <= 1'b0;
            rx_crc_bad <= 1'b0;
            rx_ecc_bad <= 1'b0;
            rx_ecc_fixable <= 1'b0;
            vact_region <= 1'b0;
        end else begin
            bta_want <= ev_cmd[5];
            tx_end <= ev_cmd[4];
            rx_eotp_seen <= ev_cmd[3];
            rx_crc_bad <= ev_cmd[2];
            rx_ecc_bad <= ev_cmd[1];
            rx_ecc_fixable <= ev_cmd[0];
            vact_region <= vact_cmd;
        end
    end
endmodule

// ### testbench/dsi_host_dpi_packet_config_test.sv
// Register bank bench: bus reads and writes, checks on the config ports
module dsi_host_dpi_packet_config_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [11:0] OFS [6] = '{hdpc_pkg::OFS_PIXFMT,
        hdpc_pkg::OFS_POL, hdpc_pkg::OFS_BUDGET, hdpc_pkg::OFS_PKTHDL,
        hdpc_pkg::OFS_RDVC, hdpc_pkg::OFS_MODE};
    localparam logic [31:0] MASK [6] = '{32'h0000010f, 32'h0000001f,
        32'h00ff00ff, 32'h0000001f, 32'h00000003, 32'h00000001};
    localparam logic [4:0] PAT [4] = '{5'h00, 5'h1f, 5'h15, 5'h0a};

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans, pixel_config, readback_vc;
    logic [2:0] hsize, pixel_class;
    logic [31:0] haddr, hwdata, hrdata;
    logic [4:0] pins;
    logic [23:0] dpi_pixel, video_pixel;
    logic dpi_pixel_valid, video_pixel_valid, vact_region, vact_cmd;
    logic hsync_act, vsync_act, de_act, shutd_act, colorm_act;
    logic loose_pack_enable, video_enable, turnaround_request_enable;
    logic [7:0] lp_budget_outside, lp_budget_inside, lp_budget_now;
    logic bta_want, bta_request, tx_end, tx_eotp_send, rx_eotp_seen;
    logic rx_eotp_accept, rx_crc_bad, crc_error, rx_ecc_bad;
    logic rx_ecc_fixable, ecc_error, ecc_correct;
    logic rx_end_packet_enable, tx_end_packet_enable;
    logic [5:0] ev_cmd;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    hdpc_regs u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp,
        .dpi_hsync(pins[2]), .dpi_vsync(pins[1]), .dpi_de(pins[0]),
        .dpi_shutd(pins[3]), .dpi_colorm(pins[4]), .dpi_pixel,
        .dpi_pixel_valid, .hsync_act, .vsync_act, .de_act, .shutd_act,
        .colorm_act, .pixel_class, .pixel_config, .loose_pack_enable,
        .video_pixel, .video_pixel_valid, .vact_region, .lp_budget_outside,
        .lp_budget_inside, .lp_budget_now, .bta_want, .bta_request, .tx_end,
        .tx_eotp_send, .rx_eotp_seen, .rx_eotp_accept, .rx_crc_bad,
        .crc_error, .rx_ecc_bad, .rx_ecc_fixable, .ecc_error, .ecc_correct,
        .rx_end_packet_enable, .tx_end_packet_enable,
        .turnaround_request_enable, .readback_vc, .video_enable
    );

    hdpc_panel_model u_panel (
        .hclk, .hresetn, .ev_cmd, .vact_cmd, .bta_want, .tx_end,
        .rx_eotp_seen, .rx_crc_bad, .rx_ecc_bad, .rx_ecc_fixable,
        .vact_region
    );

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    // Clock of 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Verdict and end of run
    task automatic summarize;
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compare one value and report a mismatch
    task automatic chk(input string nm, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One single word transfer; entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(nm, exp, x);
    endtask

    // Let registered outputs follow the latest inputs
    task automatic settle;
        repeat (4) @(posedge hclk);
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        int k, cls, cfg;
        logic [4:0] b;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        pins = 5'h00;
        dpi_pixel = 24'h000000;
        dpi_pixel_valid = 1'b0;
        ev_cmd = 6'h00;
        vact_cmd = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("class_rst", 32'h1, pixel_class);
        chk("cfg_rst", 32'h1, pixel_config);
        // Reset values, reserved bits read zero, unmapped place ignored
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset", OFS[i], 32'h0);
            wr(OFS[i], 32'hffffffff);
            rd_chk("mask", OFS[i], MASK[i]);
            wr(OFS[i], 32'h0);
        end
        wr(12'h020, 32'hffffffff);
        rd_chk("unmapped", 12'h020, 32'h0);
        // Every format code, loose packing requested throughout
        for (int c = 0; c < 16; c++) begin
            wr(hdpc_pkg::OFS_PIXFMT, 32'h100 | c);
            settle();
            k = c % 8;
            cls = (k < 3) ? 1 : (k < 5) ? 2 : 4;
            cfg = (k < 3) ? k + 1 : (k < 5) ? k - 2 : 0;
            chk("class", cls, pixel_class);
            chk("config", cfg, pixel_config);
            chk("loose", cls == 2, loose_pack_enable);
        end
        // Packed 18-bit: packet size upstream kept a multiple of four
        wr(hdpc_pkg::OFS_PIXFMT, 32'h4);
        settle();
        chk("packed", 32'h0, loose_pack_enable);
        // Pin polarity against pin levels
        for (int i = 0; i < 4; i++) begin
            wr(hdpc_pkg::OFS_POL, PAT[i]);
            for (int j = 0; j < 4; j++) begin
                pins <= PAT[j] ^ 5'h06;
                settle();
                chk("pins", PAT[j] ^ 5'h06 ^ PAT[i], {colorm_act, shutd_act,
                    hsync_act, vsync_act, de_act});
            end
        end
        // Outside budget kept at the least that fits control commands
        wr(hdpc_pkg::OFS_BUDGET, 32'h0004009a);
        settle();
        chk("bud_out", 32'h04, lp_budget_outside);
        chk("bud_in", 32'h9a, lp_budget_inside);
        chk("bud_now_out", 32'h04, lp_budget_now);
        rd_chk("status", hdpc_pkg::OFS_STATUS, 32'h2206);
        vact_cmd <= 1'b1;
        settle();
        chk("bud_now_in", 32'h9a, lp_budget_now);
        // Link events gated by the packet handler enables
        for (int i = 0; i < 4; i++) begin
            b = PAT[i];
            wr(hdpc_pkg::OFS_PKTHDL, b);
            for (int f = 0; f < 2; f++) begin
                ev_cmd <= {5'h1f, f[0]};
                settle();
                chk("bta", b[2], bta_request);
                chk("eot_tx", b[0], tx_eotp_send);
                chk("eot_rx", b[1], rx_eotp_accept);
                chk("crc", b[4], crc_error);
                chk("ecc", b[3], ecc_error);
                chk("ecc_fix", b[3] & f[0], ecc_correct);
                chk("pkt_en", b[2:0], {turnaround_request_enable,
                    rx_end_packet_enable, tx_end_packet_enable});
            end
        end
        ev_cmd <= 6'h00;
        settle();
        chk("quiet", 32'h0, {bta_request, tx_eotp_send, rx_eotp_accept,
            crc_error, ecc_error, ecc_correct});
        // Read-back channel values
        for (int v = 0; v < 4; v++) begin
            wr(hdpc_pkg::OFS_RDVC, v);
            settle();
            chk("vc", v, readback_vc);
        end
        // Pixels pass only in video mode
        dpi_pixel <= 24'h5a3c96;
        dpi_pixel_valid <= 1'b1;
        settle();
        chk("vid_off", 32'h0, video_pixel_valid);
        wr(hdpc_pkg::OFS_MODE, 32'h1);
        settle();
        chk("vid_en", 32'h1, video_enable);
        chk("vid_on", 32'h1, video_pixel_valid);
        chk("vid_pix", 32'h5a3c96, video_pixel);
        wr(hdpc_pkg::OFS_MODE, 32'h0);
        settle();
        chk("vid_stop", 32'h0, video_pixel_valid);
        // Reset in mid-run clears the bank
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("rst2", hdpc_pkg::OFS_BUDGET, 32'h0);
        chk("vc_rst2", 32'h0, readback_vc);
        rd_chk("status_rst2", hdpc_pkg::OFS_STATUS, 32'h112c);
        summarize();
    end
endmodule
